// ==== hdl/gpp_port.sv ====
// Purpose: general pin port with timer output on pin 3
// Assumes: cpu writes/reads the control word at its data address, one-cycle strobes
// Notes: outputs registered; read data registered one cycle after read strobe
//
// Overview of operation
// - one control register at data address 0x3c governs all four pins
// - bits 11..8 give pin direction, 1 output, cleared at reset
// - an output pin drives the level in its value bit 3..0
// - an input pin reads back its pin level as delivered by the synchroniser
// - timer select bit 15 puts timer output on pin 3, readable there
// - with timer select 0, its reset value, pin 3 is ordinary
// - reserved bits 14..12 and 7..4 have no effect on pins
// - pin 2 stays general; as input it also feeds the branch condition
// - timer may reach pin 3 only while external interface select is 0
`include "gpp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module gpp_port
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // cpu data bus
  input wire logic [15:0] bus_addr,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire gpp_pkg::gpp_word_t bus_wdata,
  output logic [15:0] bus_rdata,
  // system signals
  input wire logic timer_out,
  input wire logic external_interface_select,
  output logic branch_condition_input,
  // pins
  input wire gpp_pkg::gpp_pins_t pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);
  import gpp_pkg::*;
  localparam gpp_word_t ctrl_reset_word = `GPP_CTRL_RESET;
  typedef struct packed
  {
    logic timer_out_select;
    gpp_pins_t pin_direction;
    gpp_pins_t pin_value;
    gpp_word_t rdata;
    gpp_pins_t out;
    gpp_pins_t oe;
    logic branch;
  } gpp_state_t;
  gpp_state_t st_reg;
  gpp_state_t st_next;
  gpp_pins_t pin_level;
  gpp_sync u_sync
  (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .pin_raw(pin_in),
    .pin_clean(pin_level)
  );
  logic sel_hit;
  logic timer_on;
  gpp_pins_t eff_oe;
  gpp_pins_t eff_out;
  gpp_pins_t rd_val;
  assign sel_hit = (bus_addr == `GPP_CTRL_ADDR);
  assign timer_on = st_reg.timer_out_select && !external_interface_select;
  ////////////////////////////////////////////////////////////////////////
  // per-pin drive, enable and read-back value
  for (genvar g = 0; g < `GPP_NPINS; g++)
  begin : g_pin
    logic timer_here;
    // only the timer pin can be taken over, and only while external interface select is 0
    assign timer_here = timer_on && (g == `GPP_TIMER_PIN);
    assign eff_oe[g] = timer_here ? 1'b1 : st_reg.pin_direction[g];
    assign eff_out[g] = timer_here ? timer_out : st_reg.pin_value[g];
    assign rd_val[g] = eff_oe[g] ? eff_out[g] : pin_level[g];
  end
  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_next = st_reg;
    if (bus_wr && sel_hit)
    begin
      st_next.timer_out_select = bus_wdata[`GPP_TIMER_OUT_SELECT_BIT];
      st_next.pin_direction = bus_wdata[`GPP_DIR_HI:`GPP_DIR_LO];
      st_next.pin_value = bus_wdata[`GPP_VAL_HI:`GPP_VAL_LO];
    end
    st_next.rdata = `GPP_RDATA_IDLE;
    if (bus_rd && sel_hit)
    begin
      st_next.rdata[`GPP_TIMER_OUT_SELECT_BIT] = st_reg.timer_out_select;
      st_next.rdata[`GPP_DIR_HI:`GPP_DIR_LO] = st_reg.pin_direction;
      st_next.rdata[`GPP_VAL_HI:`GPP_VAL_LO] = rd_val;
    end
    st_next.out = eff_out;
    st_next.oe = eff_oe;
    // branch follows pin 2 only while it is an input
    st_next.branch = st_reg.pin_direction[`GPP_BRANCH_PIN] ? `GPP_BRANCH_IDLE : pin_level[`GPP_BRANCH_PIN];
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.timer_out_select <= ctrl_reset_word[`GPP_TIMER_OUT_SELECT_BIT];
      st_reg.pin_direction <= ctrl_reset_word[`GPP_DIR_HI:`GPP_DIR_LO];
      st_reg.pin_value <= ctrl_reset_word[`GPP_VAL_HI:`GPP_VAL_LO];
      st_reg.branch <= `GPP_BRANCH_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign bus_rdata = st_reg.rdata;
  assign pin_out = st_reg.out;
  assign pin_oe = st_reg.oe;
  assign branch_condition_input = st_reg.branch;
  ////////////////////////////////////////////////////////////////////////
  property p_dir_reset;
    @(posedge sys_clk) !rst_b
      |=> pin_oe == '0 && pin_out == '0 && branch_condition_input == `GPP_BRANCH_RESET;
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("pins not inputs after reset");
  property p_write;
    @(posedge sys_clk) disable iff (!rst_b)
      bus_wr && sel_hit && !bus_wdata[`GPP_TIMER_OUT_SELECT_BIT] ##1 !(bus_wr && sel_hit)
      |=> pin_oe == $past(bus_wdata[`GPP_DIR_HI:`GPP_DIR_LO], 2);
  endproperty
  a_write: assert property (p_write) else $error("direction not applied");
  property p_drive;
    @(posedge sys_clk) disable iff (!rst_b)
      st_reg.pin_direction[0] |=> pin_out[0] == $past(st_reg.pin_value[0]);
  endproperty
  a_drive: assert property (p_drive) else $error("output pin level wrong");
  sequence s_rd_in;
    bus_rd && sel_hit && !eff_oe[0];
  endsequence
  property p_readin;
    @(posedge sys_clk) disable iff (!rst_b) s_rd_in |=> bus_rdata[0] == $past(pin_level[0]);
  endproperty
  a_readin: assert property (p_readin) else $error("input read wrong");
  property p_timer;
    @(posedge sys_clk) disable iff (!rst_b)
      timer_on |=> pin_oe[`GPP_TIMER_PIN] && pin_out[`GPP_TIMER_PIN] == $past(timer_out);
  endproperty
  a_timer: assert property (p_timer) else $error("timer not on pin 3");
  property p_notimer;
    @(posedge sys_clk) disable iff (!rst_b)
      !timer_on |=> pin_oe[`GPP_TIMER_PIN] == $past(st_reg.pin_direction[`GPP_TIMER_PIN]);
  endproperty
  a_notimer: assert property (p_notimer) else $error("pin 3 not ordinary");
  property p_branch;
    @(posedge sys_clk) disable iff (!rst_b)
      !st_reg.pin_direction[`GPP_BRANCH_PIN] |=> branch_condition_input == $past(pin_level[`GPP_BRANCH_PIN]);
  endproperty
  a_branch: assert property (p_branch) else $error("branch input wrong");
  property p_res;
    @(posedge sys_clk) disable iff (!rst_b)
      bus_rd && sel_hit |=> bus_rdata[`GPP_RSVH_HI:`GPP_RSVH_LO] == '0
        && bus_rdata[`GPP_RSVL_HI:`GPP_RSVL_LO] == '0;
  endproperty
  a_res: assert property (p_res) else $error("reserved bits nonzero");
  ////////////////////////////////////////////////////////////////////////
  // every pin follows its own direction and value bits, pin 3 only while the timer is off
  for (genvar k = 0; k < `GPP_NPINS; k++)
  begin : g_pin_chk
    property p_pin_drive;
      @(posedge sys_clk) disable iff (!rst_b)
        st_reg.pin_direction[k] && (k != `GPP_TIMER_PIN || !timer_on)
          |=> pin_oe[k] && pin_out[k] == $past(st_reg.pin_value[k]);
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin drive level wrong");
    property p_pin_read;
      @(posedge sys_clk) disable iff (!rst_b)
        bus_rd && sel_hit && !st_reg.pin_direction[k] && (k != `GPP_TIMER_PIN || !timer_on)
          |=> bus_rdata[`GPP_VAL_LO + k] == $past(pin_level[k]);
    endproperty
    a_pin_read: assert property (p_pin_read) else $error("input pin read wrong");
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_wr_miss;
    bus_wr && !sel_hit;
  endsequence
  property p_wr_miss;
    @(posedge sys_clk) disable iff (!rst_b)
      s_wr_miss |=> $stable(st_reg.timer_out_select) && $stable(st_reg.pin_direction)
        && $stable(st_reg.pin_value);
  endproperty
  a_wr_miss: assert property (p_wr_miss) else $error("write to other address stored");
  property p_rd_idle;
    @(posedge sys_clk) disable iff (!rst_b)
      !(bus_rd && sel_hit) |=> bus_rdata == `GPP_RDATA_IDLE;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_rd_fields;
    @(posedge sys_clk) disable iff (!rst_b)
      bus_rd && sel_hit |=> bus_rdata[`GPP_TIMER_OUT_SELECT_BIT] == $past(st_reg.timer_out_select)
        && bus_rdata[`GPP_DIR_HI:`GPP_DIR_LO] == $past(st_reg.pin_direction);
  endproperty
  a_rd_fields: assert property (p_rd_fields) else $error("control fields read wrong");
  property p_timer_read;
    @(posedge sys_clk) disable iff (!rst_b)
      bus_rd && sel_hit && timer_on |=> bus_rdata[`GPP_VAL_LO + `GPP_TIMER_PIN] == $past(timer_out);
  endproperty
  a_timer_read: assert property (p_timer_read) else $error("timer level not readable");
  property p_fallback;
    @(posedge sys_clk) disable iff (!rst_b)
      st_reg.timer_out_select && external_interface_select
        |=> pin_out[`GPP_TIMER_PIN] == $past(st_reg.pin_value[`GPP_TIMER_PIN]);
  endproperty
  a_fallback: assert property (p_fallback) else $error("pin 3 did not fall back");
  property p_branch_out;
    @(posedge sys_clk) disable iff (!rst_b)
      st_reg.pin_direction[`GPP_BRANCH_PIN] |=> branch_condition_input == `GPP_BRANCH_IDLE;
  endproperty
  a_branch_out: assert property (p_branch_out) else $error("branch not idle for output pin");
  property p_pins_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      !(bus_wr && sel_hit) ##1 (!(bus_wr && sel_hit) && $stable(timer_on)) |=> $stable(pin_oe);
  endproperty
  a_pins_hold: assert property (p_pins_hold) else $error("pin enables changed unasked");
endmodule : gpp_port
`default_nettype wire

// ==== hdl/gpp_sync.sv ====
// Purpose: three-stage pin synchroniser, change accepted when stages 2 and 3 agree
// Assumes: one clock, synchronous active-low reset
// Notes: stage 1 feeds only stage 2
`include "gpp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module gpp_sync
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // pins
  input wire gpp_pkg::gpp_pins_t pin_raw,
  output logic [3:0] pin_clean
);
  import gpp_pkg::*;
  typedef struct packed
  {
    gpp_pins_t s1;
    gpp_pins_t s2;
    gpp_pins_t s3;
    gpp_pins_t clean;
  } gpp_sync_state_t;
  gpp_sync_state_t st_reg;
  gpp_sync_state_t st_next;
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin_raw;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    for (int i = 0; i < `GPP_NPINS; i++)
    begin
      if (st_reg.s2[i] == st_reg.s3[i])
      begin
        st_next.clean[i] = st_reg.s3[i];
      end
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
    end
    else
    begin
      st_reg <= st_next;
    end
  end
  assign pin_clean = st_reg.clean;
endmodule : gpp_sync
`default_nettype wire

// ==== shared/gpp_consts.svh ====
// Purpose: constants of the general pin port
// Assumes: 16-bit cpu data bus, word addresses
// Notes: field positions and reset values
`ifndef GPP_CONSTS_SVH
`define GPP_CONSTS_SVH
`define GPP_CTRL_ADDR 16'h003c
`define GPP_TIMER_OUT_SELECT_BIT 15
`define GPP_DIR_HI 11
`define GPP_DIR_LO 8
`define GPP_VAL_HI 3
`define GPP_VAL_LO 0
`define GPP_NPINS 4
`define GPP_TIMER_PIN 3
`define GPP_BRANCH_PIN 2
`define GPP_RSVH_HI 14
`define GPP_RSVH_LO 12
`define GPP_RSVL_HI 7
`define GPP_RSVL_LO 4
`define GPP_RDATA_IDLE 16'h0000
`define GPP_BRANCH_RESET 1'b1
`define GPP_BRANCH_IDLE 1'b1
`define GPP_CTRL_RESET 16'h0000
`define GPP_CTRL_WMASK 16'h8f0f
`endif

// ==== shared/gpp_pkg.sv ====
// Purpose: types of the general pin port
// Assumes: four pins per subsystem
// Notes: none
package gpp_pkg;
  typedef logic [15:0] gpp_word_t;
  typedef logic [3:0] gpp_pins_t;
endpackage : gpp_pkg

// ==== testbench/gpp_pins_model.sv ====
// Purpose: external devices on the four port pins
// Assumes: a pin the port drives shows the port's level
// Notes: undriven pins take the level the bench sets
`timescale 1ns/10ps
`default_nettype none
module gpp_pins_model
(
  // port side
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  // bench side
  input wire logic [3:0] ext_level,
  output logic [3:0] pin_level
);
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : gpp_pins_model
`default_nettype wire

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the general pin port
// Assumes: one-cycle bus strobes, pins settle within six cycles
// Notes: reset and address cases first, then table rows, then a second reset
`timescale 1ns/10ps
`default_nettype none
module tb;
  import gpp_pkg::*;
  typedef struct {logic [15:0] w; logic [3:0] e; logic t, x; logic [3:0] oe, po; logic [15:0] r; logic b;} gpp_row_t;
  logic sys_clk = 0, rst_b = 0, bus_wr = 0, bus_rd = 0, tmr = 0, xsel = 0, br;
  logic [15:0] bus_addr = 16'h003c, bus_wdata = 16'h0000, bus_rdata, rd;
  logic [3:0] pin_out, pin_oe, pins, ext = 4'h0;
  int num_errors = 0, checked = 0;
  gpp_row_t rows [5];
  ////////////////////////////////////////////////////////////
  initial forever #20 sys_clk = ~sys_clk;
  gpp_port i_dut(.sys_clk(sys_clk), .rst_b(rst_b), .bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .timer_out(tmr), .external_interface_select(xsel),
    .branch_condition_input(br), .pin_in(pins), .pin_out(pin_out), .pin_oe(pin_oe));
  gpp_pins_model i_pins(.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_level(pins));
  ////////////////////////////////////////////////////////////
  task chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_wdata <= d;
    bus_wr <= 1'b1;
    @(posedge sys_clk);
    bus_wr <= 1'b0;
  endtask : wr
  task rdt(input logic [15:0] a);
    @(posedge sys_clk);
    bus_addr <= a;
    bus_rd <= 1'b1;
    @(posedge sys_clk);
    bus_rd <= 1'b0;
    #1 rd = bus_rdata;
  endtask : rdt
  task results;
    $display("checked %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{'{16'h0f05, 4'h0, 0, 0, 4'hf, 4'h5, 16'h0f05, 1},
             '{16'hf0f0, 4'h1, 1, 0, 4'h8, 4'h8, 16'h8009, 0},
             '{16'h8000, 4'hb, 1, 1, 4'h0, 4'h0, 16'h800b, 0},
             '{16'h0c0a, 4'h3, 1, 0, 4'hc, 4'h8, 16'h0c0b, 1},
             '{16'h8000, 4'h4, 0, 0, 4'h8, 4'h0, 16'h8004, 1}};
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk({12'h000, pin_oe}, 16'h0000);
    chk({15'h0000, br}, 16'h0001);
    rdt(16'h003c);
    chk(rd, 16'h0000);
    $display("reset test done");
    wr(16'h003d, 16'h0f0f);
    rdt(16'h003d);
    chk(rd, 16'h0000);
    chk({12'h000, pin_oe}, 16'h0000);
    $display("address test done");
    foreach (rows[i])
    begin
      @(posedge sys_clk);
      ext <= rows[i].e;
      tmr <= rows[i].t;
      xsel <= rows[i].x;
      wr(16'h003c, rows[i].w);
      repeat (6) @(posedge sys_clk);
      #1 chk({12'h000, pin_oe}, {12'h000, rows[i].oe});
      chk({12'h000, pin_out & pin_oe}, {12'h000, rows[i].po});
      chk({15'h0000, br}, {15'h0000, rows[i].b});
      rdt(16'h003c);
      chk(rd, rows[i].r);
      $display("row %0d done", i);
    end
    // reset again with pins driven, then the port must let go of them
    @(posedge sys_clk);
    rst_b <= 1'b0;
    ext <= 4'h0;
    repeat (4) @(posedge sys_clk);
    rst_b <= 1'b1;
    #1 chk({12'h000, pin_oe}, 16'h0000);
    chk({15'h0000, br}, 16'h0001);
    rdt(16'h003c);
    chk(rd, 16'h0000);
    $display("mid-run reset test done");
    results();
  end
endmodule : tb
`default_nettype wire
